// >>> verilog/ubg_pkg.sv
// Package for the baud generator and receiver interrupt block.
package ubg_pkg;
    localparam int UBG_DIV_W = 16;
    localparam int UBG_OVERSAMPLE = 16;
    localparam logic [15:0] UBG_DIV_RST = 16'h0000;
    localparam logic [3:0] UBG_OVS_LAST = 4'hF;
    localparam logic [1:0] UBG_SCHEME_RST = 2'h0;
    localparam logic [7:0] UBG_ADDR_RST = 8'h00;

    // Receiver configuration as software sets it.
    typedef struct packed {
        logic rx_enable;
        logic tx_enable_bit;
        logic parity_enable;
        logic parity_odd;
        logic multiproc_enable;
        logic [1:0] addr_match_scheme;
        logic errors_only;
        logic divisor_timer_irq_enable;
    } ubg_cfg_t;

    // Receive events coming from the receiver datapath.
    typedef struct packed {
        logic data_valid;
        logic error;
        logic addr_char;
        logic [7:0] data;
    } ubg_rx_evt_t;
endpackage : ubg_pkg

// >>> verilog/ubg_core.sv
// Baud divisor counter, timer mode and receiver interrupt logic.
module ubg_core
    import ubg_pkg::*;
#(
    parameter int DIV_W = UBG_DIV_W
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire ubg_cfg_t CFG,
    input wire logic [7:0] DIV_HIGH,
    input wire logic [7:0] DIV_LOW,
    input wire logic [7:0] NODE_ADDR,
    input wire ubg_rx_evt_t RX_EVT,
    output logic BAUD_TICK,
    output logic BIT_TICK,
    output logic RELOAD_PULSE,
    output logic RX_IRQ,
    output logic RX_ACCEPT,
    output logic PARITY_ACTIVE,
    output logic ADDR_MATCH,
    output logic [7:0] RX_DATA
);
    logic [DIV_W-1:0] divisor;
    logic [DIV_W-1:0] cnt_q;
    logic [3:0] ovs_q;
    logic running;
    logic timer_mode;
    logic reload;
    logic addr_hit_q;
    logic pass_data;

    // True for the schemes that compare address characters against the node address.
    function automatic logic is_auto_scheme(input logic [1:0] scheme);
        return scheme != 2'h0;
    endfunction : is_auto_scheme

    // The divisor is the high byte over the low byte.
    assign divisor = DIV_W'({DIV_HIGH, DIV_LOW});
    assign timer_mode = !CFG.rx_enable && !CFG.tx_enable_bit;
    // In timer mode the counter runs only when its interrupt is enabled.
    assign running = timer_mode ? CFG.divisor_timer_irq_enable : 1'b1;
    assign reload = running && (divisor != '0) && (cnt_q <= DIV_W'(1));

    // Down counter that reloads every divisor cycles; a zero divisor holds it.
    // A new divisor lands only at the next reload, so one old period still runs out.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            cnt_q <= DIV_W'(UBG_DIV_RST);
        end else if (!running || divisor == '0) begin
            cnt_q <= divisor;
        end else if (reload) begin
            cnt_q <= divisor;
        end else begin
            cnt_q <= cnt_q - DIV_W'(1);
        end
    end

    // Oversample counter: one bit per sixteen reloads.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ovs_q <= 4'h0;
        end else if (timer_mode) begin
            ovs_q <= 4'h0;
        end else if (reload) begin
            ovs_q <= ovs_q + 4'h1;
        end
    end

    // Registered tick outputs.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            RELOAD_PULSE <= 1'b0;
            BAUD_TICK <= 1'b0;
            BIT_TICK <= 1'b0;
        end else begin
            RELOAD_PULSE <= reload;
            BAUD_TICK <= reload && !timer_mode;
            BIT_TICK <= reload && !timer_mode && ovs_q == UBG_OVS_LAST;
        end
    end

    assign RX_ACCEPT = CFG.rx_enable;
    assign PARITY_ACTIVE = CFG.parity_enable && !CFG.multiproc_enable;

    // Address matching: scheme 0 passes all; others compare node address.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            addr_hit_q <= 1'b0;
        end else if (!CFG.multiproc_enable || !CFG.rx_enable) begin
            addr_hit_q <= 1'b0;
        end else if (RX_EVT.data_valid && RX_EVT.addr_char) begin
            if (!is_auto_scheme(CFG.addr_match_scheme)) begin
                addr_hit_q <= 1'b1;
            end else begin
                addr_hit_q <= (RX_EVT.data == NODE_ADDR);
            end
        end
    end
    assign ADDR_MATCH = addr_hit_q;

    // Data passes unless a non-matching node is addressed in automatic modes.
    assign pass_data = !CFG.multiproc_enable || !is_auto_scheme(CFG.addr_match_scheme) || RX_EVT.addr_char
        || addr_hit_q;

    // Received data register.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            RX_DATA <= UBG_ADDR_RST;
        end else if (CFG.rx_enable && RX_EVT.data_valid && pass_data) begin
            RX_DATA <= RX_EVT.data;
        end
    end

    // Receiver interrupt: data, errors, or divisor reload.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            RX_IRQ <= 1'b0;
        end else begin
            RX_IRQ <= (CFG.rx_enable && RX_EVT.error)
                || (CFG.rx_enable && RX_EVT.data_valid && pass_data && !CFG.errors_only)
                || (reload && CFG.divisor_timer_irq_enable);
        end
    end

    // Reload interrupt follows reload by one cycle.
    AST_RELOAD_IRQ: assert property (@(posedge SYS_CLK) disable iff (RST)
        reload && CFG.divisor_timer_irq_enable |=> RX_IRQ)
        else $error("reload did not raise interrupt");
    // Errors always interrupt when receiving.
    AST_ERR_IRQ: assert property (@(posedge SYS_CLK) disable iff (RST)
        CFG.rx_enable && RX_EVT.error |=> RX_IRQ)
        else $error("error did not raise interrupt");
    // Errors-only mode with no error or reload gives no interrupt.
    AST_ERR_ONLY: assert property (@(posedge SYS_CLK) disable iff (RST)
        CFG.errors_only && !RX_EVT.error && !reload |=> !RX_IRQ)
        else $error("interrupt in errors-only mode");
    // Parity off in multiproc mode.
    AST_PARITY: assert property (@(posedge SYS_CLK) disable iff (RST)
        CFG.multiproc_enable |-> !PARITY_ACTIVE)
        else $error("parity active in multiproc mode");
    // Counter loads divisor after reload.
    AST_RELOAD_VAL: assert property (@(posedge SYS_CLK) disable iff (RST)
        reload |=> cnt_q == $past(divisor))
        else $error("counter did not reload");
    // Reload pulse is one cycle for a steady divisor above two.
    AST_PULSE_ONE: assert property (@(posedge SYS_CLK) disable iff (RST)
        RELOAD_PULSE && $stable(divisor) && divisor > DIV_W'(2) |=> !RELOAD_PULSE)
        else $error("reload pulse too long");
    // An address character for some other node arrives under an automatic scheme.
    sequence seq_foreign_addr;
        CFG.multiproc_enable && CFG.rx_enable && is_auto_scheme(CFG.addr_match_scheme) && RX_EVT.data_valid
            && RX_EVT.addr_char && RX_EVT.data != NODE_ADDR;
    endsequence
    // An address character arrives while every address is accepted.
    sequence seq_open_addr;
        CFG.multiproc_enable && CFG.rx_enable && !is_auto_scheme(CFG.addr_match_scheme) && RX_EVT.data_valid
            && RX_EVT.addr_char;
    endsequence
    // The receiver is still listening in multiprocessor mode.
    sequence seq_still_mp;
        CFG.multiproc_enable && CFG.rx_enable;
    endsequence
    // Address compare in automatic scheme.
    AST_ADDR: assert property (@(posedge SYS_CLK) disable iff (RST)
        seq_foreign_addr ##1 seq_still_mp |-> !ADDR_MATCH)
        else $error("address matched wrongly");
    // Scheme zero accepts every address character.
    AST_ADDR_OPEN: assert property (@(posedge SYS_CLK) disable iff (RST)
        seq_open_addr ##1 seq_still_mp |-> ADDR_MATCH)
        else $error("open scheme refused an address");
    // Data after a foreign address is dropped in the automatic schemes.
    AST_DATA_DROP: assert property (@(posedge SYS_CLK) disable iff (RST)
        CFG.multiproc_enable && CFG.rx_enable && is_auto_scheme(CFG.addr_match_scheme) && !addr_hit_q
        && RX_EVT.data_valid && !RX_EVT.addr_char |=> $stable(RX_DATA))
        else $error("data kept after foreign address");
    // Accepted data interrupts unless only errors may interrupt.
    AST_DATA_IRQ: assert property (@(posedge SYS_CLK) disable iff (RST)
        CFG.rx_enable && RX_EVT.data_valid && pass_data && !CFG.errors_only |=> RX_IRQ)
        else $error("data did not raise interrupt");
    // No data taken when receiver is off.
    AST_RX_OFF: assert property (@(posedge SYS_CLK) disable iff (RST)
        !CFG.rx_enable |=> RX_DATA == $past(RX_DATA))
        else $error("data taken while disabled");
    // Stopped timer gives no reload pulse.
    AST_TIMER_OFF: assert property (@(posedge SYS_CLK) disable iff (RST)
        timer_mode && !CFG.divisor_timer_irq_enable |=> !RELOAD_PULSE)
        else $error("stopped timer reloaded");
    // Timer mode gives no baud ticks.
    AST_NO_BAUD_TIMER: assert property (@(posedge SYS_CLK) disable iff (RST)
        timer_mode |=> !BAUD_TICK)
        else $error("baud tick in timer mode");
    // Every bit tick falls on a baud tick.
    AST_BIT_ON_BAUD: assert property (@(posedge SYS_CLK) disable iff (RST)
        BIT_TICK |-> BAUD_TICK)
        else $error("bit tick without baud tick");
    // A zero divisor holds the counter still.
    AST_ZERO_DIV: assert property (@(posedge SYS_CLK) disable iff (RST)
        divisor == '0 |=> !RELOAD_PULSE)
        else $error("reload with zero divisor");
    // Every reload shows as a pulse in the next cycle.
    AST_PULSE_FOLLOWS: assert property (@(posedge SYS_CLK) disable iff (RST)
        reload |=> RELOAD_PULSE)
        else $error("reload gave no pulse");
endmodule : ubg_core

// >>> tb/ubg_peer.sv
// Remote serial peer that hands received characters to the block.
module ubg_peer
    import ubg_pkg::*;
(
    input wire logic SYS_CLK,
    output ubg_rx_evt_t RX_EVT
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        RX_EVT = '0;
    end
    // One character stands one cycle; idle data then shows its inverse.
    task automatic send(input logic [7:0] d, input logic a, input logic e);
        @(negedge SYS_CLK);
        RX_EVT = '{data_valid: !e, error: e, addr_char: a, data: d};
        @(negedge SYS_CLK);
        RX_EVT = '{data_valid: 1'b0, error: 1'b0, addr_char: !a, data: ~d};
    endtask : send
endmodule : ubg_peer

// >>> tb/tb_top.sv
// Self-checking bench for the baud divisor and receiver interrupt block.
module tb_top
    import ubg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    ubg_cfg_t cfg = '0;
    logic [7:0] div_high = 8'h00, div_low = 8'h00, node_addr = 8'h00, rx_data;
    ubg_rx_evt_t rx_evt;
    logic baud_tick, bit_tick, reload_pulse, rx_irq, rx_accept, parity_active, addr_match;
    int n_mismatch = 0, compares = 0, cycles = 0;
    // Clock of 8 ns and a cycle ceiling against hangs.
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    ubg_peer u_peer (.SYS_CLK(sys_clk), .RX_EVT(rx_evt));
    ubg_core u_dut (.SYS_CLK(sys_clk), .RST(rst), .CFG(cfg), .DIV_HIGH(div_high), .DIV_LOW(div_low),
        .NODE_ADDR(node_addr), .RX_EVT(rx_evt), .BAUD_TICK(baud_tick), .BIT_TICK(bit_tick),
        .RELOAD_PULSE(reload_pulse),
        .RX_IRQ(rx_irq), .RX_ACCEPT(rx_accept), .PARITY_ACTIVE(parity_active), .ADDR_MATCH(addr_match),
        .RX_DATA(rx_data));
    // Compares one value and counts it.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check
    // Counts cycles between two pulses of the interrupt or the bit tick.
    task automatic gap(input logic sel, output logic [15:0] n);
        int k;
        n = 16'hFFFF;
        for (k = 0; k < 2000 && (sel ? bit_tick : rx_irq) !== 1'b1; k++) @(negedge sys_clk);
        for (k = 1; k < 2000; k++) begin
            @(negedge sys_clk);
            if ((sel ? bit_tick : rx_irq) === 1'b1) begin
                n = 16'(k);
                break;
            end
        end
    endtask : gap
    // Timer mode: count loaded, port off, then interrupt enable set.
    task automatic timer_test;
        logic [15:0] n;
        @(negedge sys_clk);
        div_low = 8'h03;
        cfg = '0;
        cfg.divisor_timer_irq_enable = 1'b1;
        gap(1'b0, n);
        check(n, 16'h0003);
        check(16'(reload_pulse), 16'h0001);
        check(16'(baud_tick), 16'h0000);
        div_high = 8'h01;
        div_low = 8'h00;
        gap(1'b0, n);
        gap(1'b0, n);
        check(n, 16'h0100);
        cfg.divisor_timer_irq_enable = 1'b0;
        gap(1'b0, n);
        check(n, 16'hFFFF);
    endtask : timer_test
    // Port enabled: bit tick period is sixteen times the divisor.
    task automatic bit_test;
        logic [15:0] n, m;
        @(negedge sys_clk);
        cfg = '0;
        cfg.rx_enable = 1'b1;
        div_high = 8'h00;
        div_low = 8'h02;
        gap(1'b1, n);
        gap(1'b1, n);
        check(n, 16'h0020);
        m = 16'h0000;
        repeat (32) begin
            @(negedge sys_clk);
            m = m + 16'(baud_tick);
        end
        check(m, 16'h0010);
    endtask : bit_test
    // Receive path with the port off, on, and in errors-only mode.
    task automatic rx_test;
        @(negedge sys_clk);
        cfg = '0;
        check(16'(rx_accept), 16'h0000);
        u_peer.send(8'h33, 1'b0, 1'b0);
        check({8'h00, rx_data}, 16'h0000);
        check(16'(rx_irq), 16'h0000);
        cfg.rx_enable = 1'b1;
        #1 check(16'(rx_accept), 16'h0001);
        u_peer.send(8'h55, 1'b0, 1'b0);
        check({7'h00, rx_irq, rx_data}, 16'h0155);
        cfg.errors_only = 1'b1;
        u_peer.send(8'hAA, 1'b0, 1'b0);
        check(16'(rx_irq), 16'h0000);
        u_peer.send(8'h00, 1'b0, 1'b1);
        check(16'(rx_irq), 16'h0001);
    endtask : rx_test
    // Parity gating and address matching under every automatic scheme.
    task automatic mp_test;
        int s;
        @(negedge sys_clk);
        cfg = '0;
        cfg.rx_enable = 1'b1;
        cfg.parity_enable = 1'b1;
        #1 check(16'(parity_active), 16'h0001);
        cfg.multiproc_enable = 1'b1;
        #1 check(16'(parity_active), 16'h0000);
        node_addr = 8'h5A;
        for (s = 1; s < 4; s++) begin
            cfg.addr_match_scheme = 2'(s);
            u_peer.send(8'h5A, 1'b1, 1'b0);
            check(16'(addr_match), 16'h0001);
            u_peer.send(8'h3C, 1'b0, 1'b0);
            check({7'h00, rx_irq, rx_data}, 16'h013C);
            u_peer.send(8'h5B, 1'b1, 1'b0);
            check(16'(addr_match), 16'h0000);
            u_peer.send(8'hC3, 1'b0, 1'b0);
            check({7'h00, rx_irq, rx_data}, 16'h005B);
        end
        cfg.addr_match_scheme = 2'h0;
        u_peer.send(8'hC3, 1'b1, 1'b0);
        check(16'(addr_match), 16'h0001);
    endtask : mp_test
    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run;
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    // Reset for 20 cycles, then the scenarios in turn.
    initial begin
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        rx_test();
        mp_test();
        timer_test();
        bit_test();
        complete_run();
    end
endmodule : tb_top
